//--- bus_master_model.sv
`timescale 1ns/10ps

module bus_master_model (
    // Resolved data line
    input wire logic sda_line,
    // Bus clock, idle low; data drive, high means released
    output logic scl,
    output logic sda_drv
);
    int slow = 0;

    initial begin
        scl = 1'b0;
        sda_drv = 1'b1;
    end

    // Start or repeated start; the random lead-in keeps scl off the clk grid
    task automatic start();
        #(1 + $urandom % 13);
        sda_drv = 1'b1;
        #8 scl = 1'b1;
        #8 sda_drv = 1'b0;
        #8 scl = 1'b0;
    endtask

    // Callers stop a write only after a whole acknowledged byte, unless aborting on purpose
    task automatic stop();
        #8 sda_drv = 1'b0;
        #8 scl = 1'b1;
        #8 sda_drv = 1'b1;
        #8 scl = 1'b0;
    endtask

    // Shifts the top n of nine bits; bit 0 is the slot, left high to refuse a read byte
    task automatic xfer(input logic [8:0] v, output logic [8:0] r, input int n);
        r = 9'h1FF;
        for (int i = 8; i > 8 - n; i--) begin
            #(8 + slow) sda_drv = v[i];
            #8 scl = 1'b1;
            #8 r[i] = sda_line;
            #8 scl = 1'b0;
        end
    endtask
endmodule

//--- line_sync.sv
`timescale 1ns/10ps

module line_sync (
    // Clock and reset of the receiving domain
    input wire logic clk,
    input wire logic resetn,
    // Level from the other domain
    input wire logic din,
    output logic dout
);

    logic stage1;

    // Two flops; the first is read by nothing but the second
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            stage1 <= 1'b0;
            dout <= 1'b0;
        end else begin
            stage1 <= din;
            dout <= stage1;
        end
    end

endmodule

//--- nv_store.sv
`timescale 1ns/10ps
`include "nvref_map.svh"

module nv_store #(
    parameter int unsigned NV_WRITE_CYCLES = `NV_WRITE_NS / `CLK_PERIOD_NS
) (
    // System clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Write request from the link domain, data bundled with the toggle
    input wire logic req_tgl,
    input wire nvref_pkg::wr_kind_t wr_kind,
    input wire logic [7:0] wr_addr,
    input wire logic [7:0] wr_data,
    // Completion back to the link domain
    output logic done_tgl,
    // Register contents
    output logic [7:0] wiper,
    output logic [7:0] gp,
    output logic write_enable_latch,
    output logic write_busy
);

    localparam logic [31:0] WRITE_CYCLES = 32'(NV_WRITE_CYCLES);

    logic req_sync;
    logic req_seen;
    logic [31:0] timer;
    logic [7:0] hold_addr;
    logic [7:0] hold_data;

    line_sync u_req_sync (
        .clk(clk),
        .resetn(resetn),
        .din(req_tgl),
        .dout(req_sync)
    );

    // A new request shows as a toggle edge
    wire new_req = req_sync ^ req_seen;
    wire timer_done = write_busy && (timer == 32'h1);

    // Volatile status updates at once; nonvolatile writes run the timed cycle
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            req_seen <= 1'b0;
            done_tgl <= 1'b0;
            write_busy <= 1'b0;
            timer <= 32'h0;
            hold_addr <= 8'h00;
            hold_data <= 8'h00;
            write_enable_latch <= `WEL_RESET;
        end else if (new_req) begin
            req_seen <= req_sync;
            hold_addr <= wr_addr; // Stable: link side holds it until done
            hold_data <= wr_data;
            if (wr_kind == nvref_pkg::wr_status) begin
                write_enable_latch <= wr_data[`WEL_BIT]; // [R15]
                done_tgl <= ~done_tgl;
            end else begin
                write_busy <= 1'b1; // [R3]
                timer <= WRITE_CYCLES;
            end
        end else if (timer_done) begin
            write_busy <= 1'b0;
            timer <= 32'h0;
            done_tgl <= ~done_tgl;
        end else if (write_busy) begin
            timer <= timer - 32'h1;
        end
    end

    // Array commit at the end of the cycle; the wiper drives the tap from then on
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wiper <= `WIPER_RESET;
            gp <= `GP_RESET;
        end else if (timer_done && hold_addr == `ADDR_WIPER) begin
            wiper <= hold_data; // [R18]
        end else if (timer_done && hold_addr == `ADDR_GP) begin
            gp <= hold_data; // [R3]
        end
    end

endmodule

//--- nvref_map.svh
`ifndef NVREF_MAP_SVH
`define NVREF_MAP_SVH

// Word addresses of the register bank
`define ADDR_WIPER 8'h00
`define ADDR_GP 8'h01
`define ADDR_STATUS 8'h07

// Status register layout
`define WEL_BIT 3

// Contents after power-up recall
`define WIPER_RESET 8'h80
`define GP_RESET 8'h00
`define WEL_RESET 1'b0

// Slave address byte layout
`define SEL_PATTERN_A 3'h0
`define SEL_PATTERN_B 3'h1
`define BYTE_LAST_BIT 4'h7
`define BYTE_BITS 4'h8

// Timing
`define CLK_PERIOD_NS 100
`define NV_WRITE_NS 5000000

`endif

//--- nvref_pkg.sv
package nvref_pkg;

    // Link-side protocol states
    typedef enum logic [3:0] {
        st_idle,
        st_dev,
        st_dev_ack,
        st_word,
        st_word_ack,
        st_data_wr,
        st_wr_ack,
        st_data_rd,
        st_rd_ack,
        st_ignore
    } link_state_t;

    // Kind of write handed to the storage side
    typedef enum logic [0:0] {
        wr_status,
        wr_nv
    } wr_kind_t;

endpackage

//--- two_wire_nv_register_slave.sv
// Function
// (R1) Write: acknowledge slave address, then word address, each in ninth clock.
// (R2) Acknowledge each full data byte; master then ends with a stop.
// (R3) Stop after a valid write starts the nonvolatile storage cycle.
// (R4) During the storage cycle ignore the bus, never acknowledge, release data.
// (R5) Protected write is acknowledged but dropped; no cycle, commands still accepted.
// (R6) Master stops a write only after a full data byte and its acknowledge.
// (R7) Stop mid-byte or before first data byte plus ack aborts with no write.
// (R8) Random read: dummy write, repeated start, address; device acks and sends 8 bits.
// (R9) Master ends a read with no acknowledge, then a stop.
// (R10) Stop right after word address only loads the address counter.
// (R11) After that stop, ignore the bus until a new start.
// (R12) Current-address read returns the register at the loaded address.
// (R13) Select bits 000 and 001 both address this device.
// (R14) Acknowledge address byte only when identifier and select bits both match.
// (R15) Write-enable latch must be one for nonvolatile writes, else protected.
// (R16) Status write takes one data byte; a second byte gets no acknowledge.
// (R17) Wiper at address 0, general byte at 1, status at 7.
// (R18) After the wiper storage cycle, drive the new value to the tap select.
`timescale 1ns/10ps
`include "nvref_map.svh"

module two_wire_nv_register_slave #(
    parameter int unsigned NV_WRITE_CYCLES = `NV_WRITE_NS / `CLK_PERIOD_NS,
    parameter logic [3:0] DEVICE_ID = 4'hA // Arbitrary value
) (
    // System clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Serial link; the bus clock clocks the link logic
    input wire logic scl,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    // Analog side
    output logic [7:0] tap_select,
    output logic write_busy
);

    nvref_pkg::link_state_t state;
    nvref_pkg::link_state_t next_state;
    logic [3:0] cnt;
    logic [3:0] next_cnt;
    logic [7:0] shreg;
    logic [7:0] next_shreg;
    logic [7:0] addr_cnt;
    logic [7:0] next_addr_cnt;
    logic [7:0] data_byte;
    logic [7:0] next_data_byte;
    logic have_data;
    logic next_have_data;
    logic is_read;
    logic next_is_read;
    logic drive;
    logic next_drive;
    logic req_tgl;
    logic next_req_tgl;
    nvref_pkg::wr_kind_t wr_kind;
    nvref_pkg::wr_kind_t next_wr_kind;
    logic sda_rise;
    logic done_tgl;
    logic done_sync;
    logic [7:0] wiper;
    logic [7:0] gp;
    logic write_enable_latch;

    // Register read mux, shared by the first and later read bytes
    function automatic logic [7:0] reg_value(input logic [7:0] a, input logic [7:0] w,
                                             input logic [7:0] g, input logic e);
        logic [7:0] v;
        v = 8'h00;
        if (a == `ADDR_WIPER) begin
            v = w; // [R17]
        end else if (a == `ADDR_GP) begin
            v = g;
        end else if (a == `ADDR_STATUS) begin
            v[`WEL_BIT] = e; // Other status bits read as zero
        end
        return v;
    endfunction

    // Storage and its timed write cycle in the system clock domain
    nv_store #(
        .NV_WRITE_CYCLES(NV_WRITE_CYCLES)
    ) u_store (
        .clk(clk),
        .resetn(resetn),
        .req_tgl(req_tgl),
        .wr_kind(wr_kind),
        .wr_addr(addr_cnt),
        .wr_data(data_byte),
        .done_tgl(done_tgl),
        .wiper(wiper),
        .gp(gp),
        .write_enable_latch(write_enable_latch),
        .write_busy(write_busy)
    );

    // Completion toggle back onto the link clock
    line_sync u_done_sync (
        .clk(scl),
        .resetn(resetn),
        .din(done_tgl),
        .dout(done_sync)
    );

    // Data is sampled while the clock is high
    always_ff @(posedge scl or negedge resetn) begin
        if (!resetn) begin
            sda_rise <= 1'b1;
        end else begin
            sda_rise <= sda_in;
        end
    end

    // The bus protocol keeps data stable while the clock is high, so sda_in is
    // already synchronous here. A change seen between rise and fall is a start
    // or a stop, both of which are followed by a falling clock edge.
    wire start_cond = sda_rise && !sda_in;
    wire stop_cond = !sda_rise && sda_in;
    wire bit_in = sda_rise;
    wire [7:0] shifted = {shreg[6:0], bit_in};
    wire byte_end = (cnt == `BYTE_LAST_BIT);
    // Busy from our own request until completion returns; stays correct while
    // the bus clock is parked because the request side is local
    wire busy = req_tgl ^ done_sync;
    wire [2:0] sel_bits = shifted[3:1];
    wire sel_ok = (sel_bits == `SEL_PATTERN_A) || (sel_bits == `SEL_PATTERN_B); // [R13]
    wire id_ok = (shifted[7:4] == DEVICE_ID) && sel_ok; // [R14]
    wire [7:0] rd_value = reg_value(addr_cnt, wiper, gp, write_enable_latch);
    wire target_status = (addr_cnt == `ADDR_STATUS);
    wire target_nv = (addr_cnt == `ADDR_WIPER) || (addr_cnt == `ADDR_GP);
    // Commit only on a stop after a whole acknowledged byte, between bytes or once a second status byte is refused
    wire commit_point = have_data && ((state == nvref_pkg::st_data_wr && cnt == 4'h0) ||
                                      state == nvref_pkg::st_ignore);
    wire do_status = stop_cond && commit_point && target_status;
    wire do_nv = stop_cond && commit_point && target_nv && write_enable_latch; // [R15]

    // Link protocol, advanced on each falling bus clock edge
    always_comb begin
        next_state = state;
        next_cnt = cnt;
        next_shreg = shreg;
        next_addr_cnt = addr_cnt;
        next_data_byte = data_byte;
        next_have_data = have_data;
        next_is_read = is_read;
        next_drive = drive;
        next_req_tgl = req_tgl;
        next_wr_kind = wr_kind;
        if (start_cond) begin
            next_state = nvref_pkg::st_dev; // Repeated start lands here too [R8]
            next_cnt = 4'h0;
            next_drive = 1'b0;
            next_have_data = 1'b0;
        end else if (stop_cond) begin
            // Mid-byte or early stops fall through with no request [R7]
            next_state = nvref_pkg::st_idle; // Standby until a start [R11]
            next_drive = 1'b0;
            next_have_data = 1'b0;
            next_cnt = 4'h0;
            if (do_status || do_nv) begin
                next_req_tgl = ~req_tgl; // [R3]
                next_wr_kind = do_nv ? nvref_pkg::wr_nv : nvref_pkg::wr_status;
            end
            // Protected targets simply get no request [R5]
        end else begin
            case (state)
                nvref_pkg::st_dev: begin
                    next_shreg = shifted;
                    next_cnt = cnt + 4'h1;
                    if (byte_end) begin
                        if (id_ok && !busy) begin
                            next_state = nvref_pkg::st_dev_ack;
                            next_drive = 1'b1; // [R1] [R14]
                            next_is_read = shifted[0];
                        end else begin
                            next_state = nvref_pkg::st_ignore; // No ack while busy [R4]
                        end
                    end
                end
                nvref_pkg::st_dev_ack: begin
                    if (is_read) begin
                        next_state = nvref_pkg::st_data_rd;
                        next_shreg = {rd_value[6:0], 1'b0}; // From the address counter [R12]
                        next_drive = ~rd_value[7]; // [R8]
                        next_cnt = 4'h1;
                    end else begin
                        next_state = nvref_pkg::st_word;
                        next_drive = 1'b0;
                        next_cnt = 4'h0;
                    end
                end
                nvref_pkg::st_word: begin
                    next_shreg = shifted;
                    next_cnt = cnt + 4'h1;
                    if (byte_end) begin
                        next_addr_cnt = shifted; // Loaded even if only a stop follows [R10]
                        next_state = nvref_pkg::st_word_ack;
                        next_drive = 1'b1; // [R1]
                    end
                end
                nvref_pkg::st_word_ack: begin
                    next_state = nvref_pkg::st_data_wr;
                    next_drive = 1'b0;
                    next_cnt = 4'h0;
                end
                nvref_pkg::st_data_wr: begin
                    next_shreg = shifted;
                    next_cnt = cnt + 4'h1;
                    if (byte_end) begin
                        if (target_status && have_data) begin
                            next_state = nvref_pkg::st_ignore; // Second status byte, no ack [R16]
                        end else begin
                            next_data_byte = shifted;
                            next_state = nvref_pkg::st_wr_ack;
                            next_drive = 1'b1; // [R2]
                        end
                    end
                end
                nvref_pkg::st_wr_ack: begin
                    next_state = nvref_pkg::st_data_wr;
                    next_drive = 1'b0;
                    next_cnt = 4'h0;
                    next_have_data = 1'b1; // Byte plus ack complete [R6]
                end
                nvref_pkg::st_data_rd: begin
                    if (cnt == `BYTE_BITS) begin
                        next_state = nvref_pkg::st_rd_ack;
                        next_drive = 1'b0;
                    end else begin
                        next_drive = ~shreg[7];
                        next_shreg = {shreg[6:0], 1'b0};
                        next_cnt = cnt + 4'h1;
                    end
                end
                nvref_pkg::st_rd_ack: begin
                    if (!bit_in) begin
                        next_state = nvref_pkg::st_data_rd;
                        next_shreg = {rd_value[6:0], 1'b0};
                        next_drive = ~rd_value[7];
                        next_cnt = 4'h1;
                    end else begin
                        next_state = nvref_pkg::st_ignore; // Wait for the stop [R9]
                    end
                end
                default: begin
                    next_drive = 1'b0; // Idle and ignore keep the line released [R11]
                end
            endcase
        end
    end

    // Link state registers
    always_ff @(negedge scl or negedge resetn) begin
        if (!resetn) begin
            state <= nvref_pkg::st_idle;
            cnt <= 4'h0;
            shreg <= 8'h00;
            addr_cnt <= `ADDR_WIPER;
            data_byte <= 8'h00;
            have_data <= 1'b0;
            is_read <= 1'b0;
            drive <= 1'b0;
            req_tgl <= 1'b0;
            wr_kind <= nvref_pkg::wr_status;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            shreg <= next_shreg;
            addr_cnt <= next_addr_cnt;
            data_byte <= next_data_byte;
            have_data <= next_have_data;
            is_read <= next_is_read;
            drive <= next_drive;
            req_tgl <= next_req_tgl;
            wr_kind <= next_wr_kind;
        end
    end

    // Open drain: only ever pull low; released while the storage cycle runs [R4]
    assign sda_out = 1'b0;
    assign sda_oe_n = ~drive;
    assign tap_select = wiper; // [R18]

endmodule

//--- two_wire_nv_register_slave_monitor.sv
`timescale 1ns/10ps

module nvref_monitor #(
    parameter int unsigned NV_WRITE_CYCLES = 20
) (
    // System side
    input wire logic clk,
    input wire logic resetn,
    // Serial link
    input wire logic scl,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe_n,
    // Analog side
    input wire logic [7:0] tap_select,
    input wire logic write_busy
);
    logic s_mark;
    logic p_mark;
    logic [2:0] p_sync;
    logic [3:0] since_stop;
    logic [15:0] busy_cnt;
    logic [3:0] low_cnt;
    wire in_frame = s_mark != p_mark;

    // Frame marks move on sda edges, since a stop is far shorter than a clk period
    always_ff @(negedge sda_in or negedge resetn)
        if (!resetn) s_mark <= 1'b0;
        else if (scl) s_mark <= ~p_mark;
    always_ff @(posedge sda_in or negedge resetn)
        if (!resetn) p_mark <= 1'b0;
        else if (scl) p_mark <= s_mark;

    // Age of the last stop and length of the busy pulse, in clk cycles
    always_ff @(posedge clk or negedge resetn)
        if (!resetn) begin
            p_sync <= 3'h0;
            since_stop <= 4'hF;
            busy_cnt <= 16'h0;
        end else begin
            p_sync <= {p_sync[1:0], p_mark};
            since_stop <= (p_sync[2] != p_sync[1]) ? 4'h0 : since_stop + {3'h0, since_stop != 4'hF};
            busy_cnt <= write_busy ? busy_cnt + 16'h1 : 16'h0;
        end

    // Falls of scl over which the device held sda low without a break
    always_ff @(negedge scl or negedge resetn)
        if (!resetn) low_cnt <= 4'h0;
        else low_cnt <= sda_oe_n ? 4'h0 : low_cnt + 4'h1;

    property p_busy_len; @(posedge clk) disable iff (!resetn)
        $fell(write_busy) |-> busy_cnt inside {[NV_WRITE_CYCLES - 1:NV_WRITE_CYCLES + 1]}; endproperty
    a_busy_len: assert property (p_busy_len) else $error("busy length wrong");
    property p_busy_quiet; @(posedge clk) disable iff (!resetn) write_busy |-> sda_oe_n; endproperty
    a_busy_quiet: assert property (p_busy_quiet) else $error("sda pulled while busy");
    property p_tap_done; @(posedge clk) disable iff (!resetn) $changed(tap_select) |-> $fell(write_busy); endproperty
    a_tap_done: assert property (p_tap_done) else $error("tap moved outside cycle end");
    property p_busy_stop; @(posedge clk) disable iff (!resetn) $rose(write_busy) |-> since_stop < 4'hC; endproperty
    a_busy_stop: assert property (p_busy_stop) else $error("busy without stop");
    property p_drain; @(posedge scl) disable iff (!resetn) sda_out == 1'b0; endproperty
    a_drain: assert property (p_drain) else $error("sda driven high");
    property p_ack_frame; @(negedge scl) disable iff (!resetn) $fell(sda_oe_n) |-> in_frame; endproperty
    a_ack_frame: assert property (p_ack_frame) else $error("drive outside a frame");
    property p_run; @(negedge scl) disable iff (!resetn) low_cnt < 4'hA; endproperty
    a_run: assert property (p_run) else $error("sda held too long");
    property p_idle_free; @(posedge clk) disable iff (!resetn) !in_frame |-> sda_oe_n; endproperty
    a_idle_free: assert property (p_idle_free) else $error("sda pulled after stop");

    c_cycle: cover property (@(posedge clk) disable iff (!resetn) $fell(write_busy) && busy_cnt > 16'h8);
    c_tap: cover property (@(posedge clk) disable iff (!resetn) $changed(tap_select));
    c_ack: cover property (@(negedge scl) disable iff (!resetn) $fell(sda_oe_n));
endmodule

bind two_wire_nv_register_slave nvref_monitor #(.NV_WRITE_CYCLES(NV_WRITE_CYCLES)) i_monitor (.clk(clk),
    .resetn(resetn), .scl(scl), .sda_in(sda_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .tap_select(tap_select), .write_busy(write_busy));

//--- two_wire_nv_register_slave_tb.sv
`timescale 1ns/10ps

module two_wire_nv_register_slave_tb;
    localparam int NV = 20;
    localparam logic [3:0] DEV_ID = 4'hA; // Arbitrary value
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic scl;
    logic sda_drv;
    logic sda_out;
    logic sda_oe_n;
    logic write_busy;
    logic [7:0] tap_select;
    logic [8:0] r;
    logic [7:0] d;
    int error_cnt = 0;
    int check_count = 0;
    int mdl [8] = '{128, 0, 0, 0, 0, 0, 0, 0};
    int a;
    // Pull-up wins unless someone pulls low
    wire sda_line = sda_drv & (sda_oe_n | sda_out);

    always #50 clk = ~clk;

    two_wire_nv_register_slave #(.NV_WRITE_CYCLES(NV), .DEVICE_ID(DEV_ID)) i_dut (.clk(clk), .resetn(resetn),
        .scl(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .tap_select(tap_select),
        .write_busy(write_busy));
    bus_master_model i_master (.sda_line(sda_line), .scl(scl), .sda_drv(sda_drv));

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t seen=%0h expected=%0h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("mismatches %0d comparisons %0d", error_cnt, check_count);
        if (error_cnt == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Bounded wait on write_busy; running out ends the run
    task automatic bwait(input logic lvl, input int lim);
        for (int n = 0; write_busy !== lvl; n++) begin
            if (n == lim) begin
                error_cnt++;
                tally_and_finish();
            end
            @(negedge clk);
        end
    endtask

    // One byte and the level seen in its slot
    task automatic byte_out(input logic [7:0] b, input logic slot);
        i_master.xfer({b, 1'b1}, r, 9);
        check({7'h0, r[0]}, {7'h0, slot});
    endtask

    task automatic hdr(input logic [7:0] wa);
        @(negedge clk);
        i_master.start();
        byte_out({DEV_ID, 3'h0, 1'b0}, 1'b0);
        byte_out(wa, 1'b0);
    endtask

    // Byte write; an accepted storage write is probed while busy and followed to its end
    task automatic wr(input logic [7:0] wa, input logic [7:0] wd);
        hdr(wa);
        byte_out(wd, 1'b0);
        i_master.stop();
        if (wa == 8'h07) begin
            mdl[7] = int'(wd & 8'h08);
        end else if (wa < 8'h02 && mdl[7] != 0) begin
            i_master.start();
            byte_out({DEV_ID, 3'h0, 1'b0}, 1'b1);
            i_master.stop();
            bwait(1'b1, 10);
            bwait(1'b0, NV + 10);
            mdl[wa] = wd;
            if (wa == 8'h00) check(tap_select, wd);
        end
        repeat (10) @(negedge clk);
        check({7'h0, write_busy}, 8'h00);
    endtask

    // Read at the address counter; the byte is refused, then stop
    task automatic cur_read(input logic [2:0] sel, input int exp);
        byte_out({DEV_ID, sel, 1'b1}, 1'b0);
        i_master.xfer(9'h1FF, r, 9);
        check(r[8:1], exp[7:0]);
        i_master.stop();
    endtask

    task automatic rd(input logic [7:0] wa);
        hdr(wa);
        i_master.start();
        cur_read(3'h0, mdl[wa]);
    endtask

    initial begin
        // A real falling edge once every process waits, so the link-clock flops reset too
        #1 resetn = 1'b1;
        #1 resetn = 1'b0;
        void'($urandom(42));
        repeat (5) @(negedge clk);
        resetn = 1'b1;
        repeat (2) @(negedge clk);
        check(tap_select, 8'h80);
        for (a = 0; a < 8; a++) rd(8'(a));
        // Latch clear, so the storage write is dropped
        wr(8'h00, 8'h3C);
        rd(8'h00);
        for (a = 0; a < 8; a++) begin
            @(negedge clk);
            i_master.start();
            byte_out({a[2] ? ~DEV_ID : DEV_ID, 1'b0, a[1:0], 1'b0}, !(a[2] == 0 && a[1] == 0));
            i_master.stop();
        end
        // Status write with a second byte
        hdr(8'h07);
        byte_out(8'h08, 1'b0);
        byte_out(8'hF7, 1'b1);
        i_master.stop();
        mdl[7] = 8;
        repeat (10) @(negedge clk);
        rd(8'h07);
        // Stop in mid data byte
        hdr(8'h01);
        i_master.xfer(9'h0A5, r, 4);
        i_master.stop();
        repeat (10) @(negedge clk);
        check({7'h0, write_busy}, 8'h00);
        rd(8'h01);
        // Random storage and unmapped writes at varying master pace
        for (int k = 0; k < 6; k++) begin
            i_master.slow = $urandom % 60;
            a = $urandom % 3;
            d = 8'($urandom);
            wr(8'(a == 2 ? 3 : a), d);
            rd(8'(a == 2 ? 3 : a));
        end
        i_master.slow = 0;
        // Address set by an early stop, then clocks without a start
        hdr(8'h01);
        i_master.stop();
        i_master.xfer({DEV_ID, 3'h0, 1'b1, 1'b1}, r, 9);
        check({7'h0, r[0]}, 8'h01);
        i_master.start();
        cur_read(3'h1, mdl[1]);
        // Master acknowledges the first byte, so the same register comes again
        i_master.start();
        byte_out({DEV_ID, 3'h1, 1'b1}, 1'b0);
        i_master.xfer(9'h1FE, r, 9);
        check(r[8:1], 8'(mdl[1]));
        i_master.xfer(9'h1FF, r, 9);
        check(r[8:1], 8'(mdl[1]));
        i_master.stop();
        tally_and_finish();
    end
endmodule
